// >>> design/flash_op_timer.sv
// Down-counter that times one flash program or erase operation.
module flash_op_timer #(
    parameter int CNT_W = 18
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic [CNT_W-1:0] cycles,
    output logic busy,
    output logic done
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic busy;
        logic done;
    } timer_state_t;

    timer_state_t cur_q;
    timer_state_t nxt_d;

    initial begin
        if (CNT_W < 2) begin
            $error("flash_op_timer: CNT_W must be at least 2");
        end
    end

    // Load on start, count down while busy, pulse done in the cycle busy drops.
    always_comb begin
        nxt_d = cur_q;
        nxt_d.done = 1'b0;
        if (cur_q.busy) begin
            if (cur_q.count == CNT_W'(1)) begin
                nxt_d.busy = 1'b0;
                nxt_d.done = 1'b1;
            end else begin
                nxt_d.count = cur_q.count - CNT_W'(1);
            end
        end else if (start) begin
            nxt_d.busy = 1'b1;
            nxt_d.count = cycles;
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (reset) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign busy = cur_q.busy;
    assign done = cur_q.done;

endmodule

// >>> design/flash_pkg.sv
// Shared constants for the flash program and erase controller.
package flash_pkg;

    // ------------------------------------------------------------------
    // Geometry of the flash array and the scratchpad sector.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_BITS = 9;
    localparam int SCRATCH_BYTES = 128;
    localparam int SCRATCH_BITS = 7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------------
    // Timing of one operation at the system clock rate.
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ = 20_000_000;
    localparam int ERASE_TIME_MS = 12;
    localparam int WRITE_TIME_US = 50;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * (CLOCK_HZ / 1000);
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLOCK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Register offsets (byte addresses) and field positions.
    // ------------------------------------------------------------------
    localparam logic [3:0] PSC_OFS = 4'h0;
    localparam logic [3:0] FMC_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam int REDIRECT_BIT = 0;
    localparam int ERASE_EN_BIT = 1;
    localparam int SCRATCH_BIT = 2;
    localparam int FWE_BIT = 0;
    localparam int BUSY_BIT = 0;
    localparam int ERASING_BIT = 1;
    localparam int SW_OK_BIT = 2;
    localparam int REFUSED_BIT = 3;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam logic [7:0] FMC_RESET = 8'h80;

    // Operation sequencer states.
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_ERASE = 2'b01,
        OP_PROGRAM = 2'b10
    } op_state_t;

endpackage

// >>> design/flash_program_erase_control.sv
// Flash program and page erase controller with its Wishbone registers.
//
// Operation
// - flash programmed one byte per write
// - programming only clears bits to zero
// - erase sets whole 512-byte page (128-byte scratchpad) to FF
// - redirect bit sends data writes to flash
// - redirect bit cleared only by software
// - data reads always go to external RAM
// - code reads return flash contents
// - writes and erases need software write enable
// - erase enable plus redirect erases page
// - erase enable clear means single byte program
// - operations are timed internally, no polling
// - core stalled while operation runs
// - interrupts held until operation completes
// - scratchpad overlays 0x00-0x7F when selected
// - no instruction fetch from scratchpad
// - uninitialized part refuses software programming
module flash_program_erase_control #(
    parameter int ERASE_CYCLES = flash_pkg::ERASE_CYCLES,
    parameter int INT_N = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic coreWrStb,
    input wire logic coreRdStb,
    input wire logic [15:0] coreAddr,
    input wire logic [7:0] coreWrData,
    output logic coreStall,
    input wire logic codeRdStb,
    input wire logic codeFetch,
    input wire logic [15:0] codeAddr,
    output logic [7:0] codeData,
    output logic xramWrStb,
    output logic xramRdStb,
    output logic [15:0] xramAddr,
    output logic [7:0] xramWrData,
    input wire logic flashInitPin,
    input wire logic [INT_N-1:0] intRequest,
    output logic [INT_N-1:0] intToCore
);

    localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
    localparam int FLASH_BYTES = 1 << flash_pkg::ADDR_W;

    // ------------------------------------------------------------------
    // State record and storage arrays.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic redirect;
        logic eraseEn;
        logic scratchSel;
        logic [7:0] fmc;
        logic pinA;
        logic pinB;
        logic pinC;
        logic swAllowed;
        logic refused;
        flash_pkg::op_state_t state;
        logic opScratch;
        logic [15:0] opAddr;
        logic [8:0] eraseIdx;
        logic eraseDone;
        logic ack;
        logic [31:0] rdData;
        logic xramWr;
        logic xramRd;
        logic [15:0] xramA;
        logic [7:0] xramD;
        logic [7:0] code;
        logic [INT_N-1:0] intOut;
    } ctrl_state_t;

    ctrl_state_t cur_q;
    ctrl_state_t nxt_d;

    logic [7:0] mainMem [FLASH_BYTES];
    logic [7:0] scratchMem [flash_pkg::SCRATCH_BYTES];

    logic mainWe;
    logic [15:0] mainWAddr;
    logic [7:0] mainWData;
    logic scrWe;
    logic [6:0] scrWAddr;
    logic [7:0] scrWData;
    logic timerStart;
    logic [CNT_W-1:0] timerCycles;
    logic timerBusy;
    logic timerDone;
    logic busWrite;
    logic coreToScratch;
    logic [7:0] oldByte;
    logic [8:0] pageLast;
    logic [15:0] pageBase;

    initial begin
        if (ERASE_CYCLES < flash_pkg::PAGE_BYTES) begin
            $error("ERASE_CYCLES must cover one byte per page location");
        end
        if (INT_N < 1) begin
            $error("INT_N must be at least 1");
        end
    end

    // ------------------------------------------------------------------
    // Operation timer.
    // ------------------------------------------------------------------
    flash_op_timer #(
        .CNT_W(CNT_W)
    ) opTimer (
        .clock(clock),
        .reset(reset),
        .start(timerStart),
        .cycles(timerCycles),
        .busy(timerBusy),
        .done(timerDone)
    );

    // Helpers derived from the current state and the core request.
    always_comb begin
        busWrite = cyc_i & stb_i & we_i & cur_q.ack;
        coreToScratch = cur_q.scratchSel &
            (coreAddr[15:flash_pkg::SCRATCH_BITS] == '0);
        oldByte = coreToScratch ? scratchMem[coreAddr[6:0]] :
            mainMem[coreAddr];
        pageLast = cur_q.opScratch ? 9'(flash_pkg::SCRATCH_BYTES - 1) :
            9'(flash_pkg::PAGE_BYTES - 1);
        pageBase = {cur_q.opAddr[15:flash_pkg::PAGE_BITS], 9'h000};
    end

    // ------------------------------------------------------------------
    // Next-state logic: registers, core routing and the sequencer.
    // ------------------------------------------------------------------
    always_comb begin
        nxt_d = cur_q;
        mainWe = 1'b0;
        mainWAddr = coreAddr;
        mainWData = coreWrData;
        scrWe = 1'b0;
        scrWAddr = coreAddr[6:0];
        scrWData = coreWrData;
        timerStart = 1'b0;
        timerCycles = CNT_W'(flash_pkg::WRITE_CYCLES);

        // Strap synchroniser; the level is caught when B and C agree.
        nxt_d.pinA = flashInitPin;
        nxt_d.pinB = cur_q.pinA;
        nxt_d.pinC = cur_q.pinB;
        if (cur_q.pinB == cur_q.pinC) begin
            nxt_d.swAllowed = cur_q.pinC;
        end

        // Wishbone slave: ack one cycle after the request, then drop.
        nxt_d.ack = cyc_i & stb_i & ~cur_q.ack;
        if (cyc_i & stb_i & ~cur_q.ack) begin
            unique case (adr_i)
                flash_pkg::PSC_OFS: nxt_d.rdData = {29'h0000_0000,
                    cur_q.scratchSel, cur_q.eraseEn, cur_q.redirect};
                flash_pkg::FMC_OFS: nxt_d.rdData = {24'h00_0000, cur_q.fmc};
                flash_pkg::STAT_OFS: nxt_d.rdData = {28'h000_0000,
                    cur_q.refused, cur_q.swAllowed,
                    cur_q.state == flash_pkg::OP_ERASE,
                    cur_q.state != flash_pkg::OP_IDLE};
                default: nxt_d.rdData = 32'h0000_0000;
            endcase
        end
        if (busWrite && sel_i[0]) begin
            unique case (adr_i)
                flash_pkg::PSC_OFS: begin
                    // Only this write changes the redirect bit.
                    nxt_d.redirect = dat_i[flash_pkg::REDIRECT_BIT];
                    nxt_d.eraseEn = dat_i[flash_pkg::ERASE_EN_BIT];
                    nxt_d.scratchSel = dat_i[flash_pkg::SCRATCH_BIT];
                end
                flash_pkg::FMC_OFS: nxt_d.fmc = dat_i[7:0];
                flash_pkg::STAT_OFS: begin
                    if (dat_i[flash_pkg::REFUSED_BIT]) begin
                        nxt_d.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Core data-space traffic, registered toward the external RAM.
        nxt_d.xramWr = 1'b0;
        nxt_d.xramRd = 1'b0;
        if (coreRdStb) begin
            nxt_d.xramRd = 1'b1;
            nxt_d.xramA = coreAddr;
        end
        if (coreWrStb && cur_q.state == flash_pkg::OP_IDLE) begin
            if (!cur_q.redirect) begin
                nxt_d.xramWr = 1'b1;
                nxt_d.xramA = coreAddr;
                nxt_d.xramD = coreWrData;
            end else if (!cur_q.fmc[flash_pkg::FWE_BIT] ||
                    !cur_q.swAllowed) begin
                // Refused: flash untouched, no operation starts.
                nxt_d.refused = 1'b1;
            end else begin
                // Redirected write becomes a flash operation.
                nxt_d.opAddr = coreAddr;
                nxt_d.opScratch = coreToScratch;
                timerStart = 1'b1;
                if (cur_q.eraseEn) begin
                    nxt_d.state = flash_pkg::OP_ERASE;
                    nxt_d.eraseIdx = 9'h000;
                    nxt_d.eraseDone = 1'b0;
                    timerCycles = CNT_W'(ERASE_CYCLES);
                end else begin
                    // Single byte, bits only fall toward zero.
                    nxt_d.state = flash_pkg::OP_PROGRAM;
                    mainWe = ~coreToScratch;
                    scrWe = coreToScratch;
                    mainWData = oldByte & coreWrData;
                    scrWData = oldByte & coreWrData;
                end
            end
        end

        // Erase walks the page one byte per cycle, then waits for time.
        unique case (cur_q.state)
            flash_pkg::OP_IDLE: begin
            end
            flash_pkg::OP_ERASE: begin
                if (!cur_q.eraseDone) begin
                    mainWe = ~cur_q.opScratch;
                    scrWe = cur_q.opScratch;
                    mainWAddr = pageBase | {7'h00, cur_q.eraseIdx};
                    scrWAddr = cur_q.eraseIdx[6:0];
                    mainWData = flash_pkg::ERASED_BYTE;
                    scrWData = flash_pkg::ERASED_BYTE;
                    nxt_d.eraseIdx = cur_q.eraseIdx + 9'h001;
                    nxt_d.eraseDone = (cur_q.eraseIdx == pageLast);
                end
                if (timerDone) begin
                    nxt_d.state = flash_pkg::OP_IDLE;
                end
            end
            flash_pkg::OP_PROGRAM: begin
                if (timerDone) begin
                    nxt_d.state = flash_pkg::OP_IDLE;
                end
            end
            default: nxt_d.state = flash_pkg::OP_IDLE;
        endcase

        // Code reads: fetches never see the scratchpad.
        if (codeRdStb) begin
            if (!codeFetch && cur_q.scratchSel &&
                    codeAddr[15:flash_pkg::SCRATCH_BITS] == '0) begin
                nxt_d.code = scratchMem[codeAddr[6:0]];
            end else begin
                nxt_d.code = mainMem[codeAddr];
            end
        end

        // Interrupts are held back while an operation runs.
        nxt_d.intOut = (nxt_d.state == flash_pkg::OP_IDLE) ?
            intRequest : '0;
    end

    // State register.
    always_ff @(posedge clock) begin
        if (reset) begin
            cur_q <= '0;
            cur_q.fmc <= flash_pkg::FMC_RESET;
            cur_q.redirect <= flash_pkg::PSC_RESET[flash_pkg::REDIRECT_BIT];
            cur_q.eraseEn <= flash_pkg::PSC_RESET[flash_pkg::ERASE_EN_BIT];
            cur_q.scratchSel <= flash_pkg::PSC_RESET[flash_pkg::SCRATCH_BIT];
            cur_q.state <= flash_pkg::OP_IDLE;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // Flash and scratchpad arrays; contents survive reset.
    always_ff @(posedge clock) begin
        if (mainWe) begin
            mainMem[mainWAddr] <= mainWData;
        end
        if (scrWe) begin
            scratchMem[scrWAddr] <= scrWData;
        end
    end

    // Output assignments.
    assign dat_o = cur_q.rdData;
    assign ack_o = cur_q.ack;
    assign coreStall = (cur_q.state != flash_pkg::OP_IDLE);
    assign codeData = cur_q.code;
    assign xramWrStb = cur_q.xramWr;
    assign xramRdStb = cur_q.xramRd;
    assign xramAddr = cur_q.xramA;
    assign xramWrData = cur_q.xramD;
    assign intToCore = cur_q.intOut;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    logic startProg;
    logic startErase;
    logic [CNT_W:0] opCycles;
    assign startProg = timerStart & ~cur_q.eraseEn;
    assign startErase = timerStart & cur_q.eraseEn;

    // Counts stalled cycles of the running operation.
    always_ff @(posedge clock) begin
        if (reset || timerStart) begin
            opCycles <= '0;
        end else if (coreStall) begin
            opCycles <= opCycles + (CNT_W + 1)'(1);
        end
    end

    sequence s_progStart;
        startProg;
    endsequence
    sequence s_stallRun;
        coreStall [*8];
    endsequence

    property p_stallOnProgram;
        s_progStart |=> s_stallRun;
    endproperty
    a_stallOnProgram: assert property (p_stallOnProgram)
        else $error("core not stalled after program start");

    property p_writeDuration;
        $fell(coreStall) && $past(cur_q.state) == flash_pkg::OP_PROGRAM
            |-> opCycles == (CNT_W + 1)'(flash_pkg::WRITE_CYCLES + 1);
    endproperty
    a_writeDuration: assert property (p_writeDuration)
        else $error("byte write stall length wrong");

    property p_clearOnly;
        startProg && !coreToScratch |=>
            mainMem[$past(coreAddr)] == ($past(oldByte) & $past(coreWrData));
    endproperty
    a_clearOnly: assert property (p_clearOnly)
        else $error("program did not AND into old byte");

    property p_eraseFills;
        $fell(coreStall) && $past(cur_q.state) == flash_pkg::OP_ERASE &&
            !cur_q.opScratch |-> mainMem[pageBase] == flash_pkg::ERASED_BYTE
            && mainMem[pageBase | 16'h01FF] == flash_pkg::ERASED_BYTE;
    endproperty
    a_eraseFills: assert property (p_eraseFills)
        else $error("erased page not all ones");

    property p_noEnableNoOp;
        coreWrStb && cur_q.redirect && !cur_q.fmc[flash_pkg::FWE_BIT] &&
            !coreStall |=> !coreStall && cur_q.refused;
    endproperty
    a_noEnableNoOp: assert property (p_noEnableNoOp)
        else $error("operation started without write enable");

    property p_plainWrite;
        coreWrStb && !cur_q.redirect && !coreStall |=>
            xramWrStb && xramAddr == $past(coreAddr);
    endproperty
    a_plainWrite: assert property (p_plainWrite)
        else $error("unredirected write lost");

    property p_readsToRam;
        coreRdStb |=> xramRdStb ##1 !xramRdStb || $past(coreRdStb);
    endproperty
    a_readsToRam: assert property (p_readsToRam)
        else $error("data read not routed to external RAM");

    property p_redirectHolds;
        cur_q.redirect && !(busWrite && adr_i == flash_pkg::PSC_OFS)
            |=> cur_q.redirect;
    endproperty
    a_redirectHolds: assert property (p_redirectHolds)
        else $error("redirect bit cleared by hardware");

    property p_intHeld;
        coreStall |-> intToCore == '0;
    endproperty
    a_intHeld: assert property (p_intHeld)
        else $error("interrupt passed during operation");

    property p_fetchMain;
        codeRdStb && codeFetch |=> codeData == $past(mainMem[codeAddr]);
    endproperty
    a_fetchMain: assert property (p_fetchMain)
        else $error("fetch did not read main flash");

    property p_eraseStart;
        startErase |=> cur_q.state == flash_pkg::OP_ERASE ##1 coreStall;
    endproperty
    a_eraseStart: assert property (p_eraseStart)
        else $error("page erase not started");

endmodule

// >>> sim/core_model.sv
// Behavioural processor core that issues data and code requests.
module core_model (
    input wire logic clock,
    input wire logic coreStall,
    input wire logic [7:0] codeData,
    output logic coreWrStb,
    output logic coreRdStb,
    output logic [15:0] coreAddr,
    output logic [7:0] coreWrData,
    output logic codeRdStb,
    output logic codeFetch,
    output logic [15:0] codeAddr
);
    timeunit 1ns;
    timeprecision 1ns;

    // Every request line starts idle at time zero.
    initial begin
        coreWrStb = 1'b0;
        coreRdStb = 1'b0;
        coreAddr = 16'h0000;
        coreWrData = 8'h00;
        codeRdStb = 1'b0;
        codeFetch = 1'b0;
        codeAddr = 16'h0000;
    end

    // A data write; a stalled core issues nothing, released lines flip.
    // Writes come only from the caller, never from an interrupt handler.
    task automatic dwrite(input logic [15:0] a, input logic [7:0] d);
        while (coreStall !== 1'b0) @(posedge clock);
        coreWrStb <= 1'b1;
        coreAddr <= a;
        coreWrData <= d;
        @(posedge clock);
        coreWrStb <= 1'b0;
        coreAddr <= ~a;
        coreWrData <= ~d;
    endtask

    // A data read; its answer comes from the external data RAM.
    task automatic dread(input logic [15:0] a);
        while (coreStall !== 1'b0) @(posedge clock);
        coreRdStb <= 1'b1;
        coreAddr <= a;
        @(posedge clock);
        coreRdStb <= 1'b0;
        coreAddr <= ~a;
    endtask

    // A code read; the byte is taken one cycle after the strobe.
    task automatic cread(input logic [15:0] a, input logic f,
                         output logic [7:0] q);
        codeRdStb <= 1'b1;
        codeAddr <= a;
        codeFetch <= f;
        @(posedge clock);
        codeRdStb <= 1'b0;
        codeAddr <= ~a;
        codeFetch <= ~f;
        @(posedge clock);
        q = codeData;
    endtask
endmodule

// >>> sim/flash_program_erase_control_test.sv
// Self-checking bench for the flash program and erase controller.
module flash_program_erase_control_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals and the design.
    // ------------------------------------------------------------------
    localparam int ERASE_N = 600;
    typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    row_t rows[5] = '{'{4'h0, 32'h0000_0007, 32'h0000_0007},
        '{4'h0, 32'h0000_0000, 32'h0000_0000},
        '{4'h4, 32'h0000_0081, 32'h0000_0081},
        '{4'h4, 32'h0000_0080, 32'h0000_0080},
        '{4'hC, 32'h0000_00FF, 32'h0000_0000}};
    logic clock, reset, cyc, stb, we, ack, flashInitPin;
    logic [3:0] adr, sel;
    logic [31:0] datI, datO;
    logic coreWrStb, coreRdStb, coreStall, codeRdStb, codeFetch;
    logic xramWrStb, xramRdStb;
    logic [15:0] coreAddr, codeAddr, xramAddr;
    logic [7:0] coreWrData, codeData, xramWrData, intRequest, intToCore;
    int fail_count, checks;

    flash_program_erase_control #(.ERASE_CYCLES(ERASE_N)) u_dut (
        .clock(clock), .reset(reset), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI),
        .dat_o(datO), .ack_o(ack), .coreWrStb(coreWrStb),
        .coreRdStb(coreRdStb), .coreAddr(coreAddr),
        .coreWrData(coreWrData), .coreStall(coreStall),
        .codeRdStb(codeRdStb), .codeFetch(codeFetch),
        .codeAddr(codeAddr), .codeData(codeData),
        .xramWrStb(xramWrStb), .xramRdStb(xramRdStb),
        .xramAddr(xramAddr), .xramWrData(xramWrData),
        .flashInitPin(flashInitPin), .intRequest(intRequest),
        .intToCore(intToCore));

    core_model u_core (
        .clock(clock), .coreStall(coreStall), .codeData(codeData),
        .coreWrStb(coreWrStb), .coreRdStb(coreRdStb),
        .coreAddr(coreAddr), .coreWrData(coreWrData),
        .codeRdStb(codeRdStb), .codeFetch(codeFetch),
        .codeAddr(codeAddr));

    // ------------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------------
    // Compares a value and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= 4'h1;
        we <= w;
        adr <= a;
        datI <= d;
        do @(posedge clock); while (ack !== 1'b1);
        r = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        datI <= ~d;
        @(posedge clock);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, r);
        chk(r, e);
    endtask

    // Core write, then counts stalled cycles and watches interrupts.
    task automatic op(input logic [15:0] a, input logic [7:0] d,
                      input int e);
        int n;
        n = 0;
        u_core.dwrite(a, d);
        @(posedge clock);
        chk({xramWrStb, intToCore}, {1'b0, (e > 0) ? 8'h00 : intRequest});
        while (coreStall === 1'b1 && n < 300000) begin
            n++;
            @(posedge clock);
        end
        chk(n, e);
        @(posedge clock);
        chk(intToCore, intRequest);
    endtask

    task automatic cr(input logic [15:0] a, input logic f,
                      input logic [7:0] e);
        logic [7:0] q;
        u_core.cread(a, f, q);
        chk(q, e);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence.
    // ------------------------------------------------------------------
    // Free-running 20 MHz clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        complete_run();
    end

    // Main sequence: reset, register rows, then flash operations.
    initial begin
        reset = 1'b1;
        {cyc, stb, we, adr, datI} = '0;
        sel = 4'h1;
        flashInitPin = 1'b1;
        intRequest = 8'h05;
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (5) @(posedge clock);
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0080);
        rd(4'h8, 32'h0000_0004);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        $display("register test done");
        wr(4'h4, 32'h0000_0081);
        wr(4'h0, 32'h0000_0002);
        wr(4'h0, 32'h0000_0003);
        op(16'h0010, 8'h00, ERASE_N + 1);
        op(16'h0200, 8'h00, ERASE_N + 1);
        cr(16'h03FF, 1'b0, 8'hFF);
        wr(4'h0, 32'h0000_0001);
        op(16'h0205, 8'hA5, 1001);
        op(16'h0205, 8'h3C, 1001);
        cr(16'h0205, 1'b0, 8'h24);
        cr(16'h0204, 1'b0, 8'hFF);
        rd(4'h0, 32'h0000_0001);
        u_core.dread(16'h1234);
        @(posedge clock);
        chk({xramRdStb, xramAddr}, {1'b1, 16'h1234});
        $display("program test done");
        wr(4'h4, 32'h0000_0080);
        op(16'h0206, 8'h00, 0);
        cr(16'h0206, 1'b0, 8'hFF);
        rd(4'h8, 32'h0000_000C);
        wr(4'h8, 32'h0000_0008);
        rd(4'h8, 32'h0000_0004);
        wr(4'h4, 32'h0000_0081);
        wr(4'h0, 32'h0000_0006);
        wr(4'h0, 32'h0000_0007);
        op(16'h0010, 8'h00, ERASE_N + 1);
        wr(4'h0, 32'h0000_0005);
        op(16'h0010, 8'h5A, 1001);
        cr(16'h0010, 1'b0, 8'h5A);
        cr(16'h0010, 1'b1, 8'hFF);
        cr(16'h0090, 1'b0, 8'hFF);
        $display("scratchpad test done");
        wr(4'h0, 32'h0000_0000);
        u_core.dwrite(16'h0300, 8'h11);
        @(posedge clock);
        chk({xramWrStb, xramAddr, xramWrData},
            {1'b1, 16'h0300, 8'h11});
        reset <= 1'b1;
        flashInitPin <= 1'b0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (5) @(posedge clock);
        rd(4'h8, 32'h0000_0000);
        wr(4'h4, 32'h0000_0081);
        wr(4'h0, 32'h0000_0001);
        op(16'h0207, 8'h00, 0);
        cr(16'h0207, 1'b0, 8'hFF);
        $display("strap test done");
        complete_run();
    end
endmodule
